// file: rtl/pb_channel.sv
// Push button input channel: debounce, press classes, telegram scheduling, registers
//
// Summary of operation
// (RULE1) Each object sends cyclically never, always, only on input high, or low.
// (RULE2) One cycle period of 1 to 60 minutes is shared by all objects.
// (RULE3) After bus supply returns, send nothing, update now, or after 5/10/15 s.
// (RULE4) Block setting: ignore, no response, act as rising or falling edge.
// (RULE5) Block release: stay silent or send an update, per object.
// (RULE6) No cyclic telegrams while the channel is blocked.
// (RULE7) New input level accepted after stable for selected debounce time.
// (RULE8) Opening contact inverts the sensed level to derive pressed.
// (RULE9) Press held at least the long threshold (300 ms to 1 s) is long.
// (RULE10) Second click starting inside the double-click window makes a double-click.
// (RULE11) One, two or three output objects are in use per channel.
// (RULE12) Disabled block function ignores the block value and all responses.
// (RULE13) Standard polarity: 1 blocks; inverted polarity: 0 blocks.
// (RULE14) Press and double-click times run from debounced edges on a ms tick.
`timescale 1ns/1ps
module pb_channel
   import pb_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = CYCLES_PER_MS
)(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic contact_i,
   input wire logic bus_supply_i,
   output logic [2:0] tx_req_o,
   output cause_t [2:0] tx_cause_o,
   output logic pressed_o,
   output logic blocked_o,
   output logic irq_o
);
   ctrl_t ctrl;
   logic [31:0] obj_cfg;
   logic blk_val;
   logic [ST_BITS-1:0] status;
   logic [ST_BITS-1:0] mask;
   logic [ST_BITS-1:0] st_set;
   logic wb_req;
   logic wb_wr;
   logic wb_rd;

   logic [16:0] tick_cnt;
   logic ms_tick;
   logic [9:0] ms_cnt;
   logic sec_tick;
   logic [5:0] sec_cnt;
   logic min_tick;
   logic [5:0] min_cnt;
   logic [5:0] cyc_min;
   logic cyc_tick;

   logic sense;
   logic pressed;
   logic [13:0] deb_cnt;
   logic [13:0] deb_ms;
   logic pressed_d;
   logic rise;
   logic fall;

   press_st_t pst;
   press_st_t next_pst;
   logic [10:0] press_ms;
   logic [10:0] long_ms;
   logic [10:0] dbl_ms;
   logic restart_t;
   chan_evt_t evt;

   logic block_act;
   logic block_d;
   logic blk_set;
   logic blk_clr;
   logic supply_d;
   logic bus_ret;
   logic [1:0] obj_count;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr,
                                         input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[8*b +: 8] = wr[8*b +: 8];
         end
      end
      return res;
   endfunction : merge

   // Wishbone classic slave: ack one cycle after the strobe, dropped the next
   assign wb_req = cyc_i & stb_i & ~ack_o;
   assign wb_wr = wb_req & we_i;
   assign wb_rd = wb_req & ~we_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= wb_req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (wb_rd) begin
         unique case (adr_i)
            ADDR_CTRL: dat_o <= ctrl;
            ADDR_OBJCFG: dat_o <= obj_cfg;
            ADDR_BLOCK: dat_o <= {{31{1'b0}}, blk_val};
            ADDR_STATUS: dat_o <= {{(32-ST_BITS){1'b0}}, status};
            ADDR_MASK: dat_o <= {{(32-ST_BITS){1'b0}}, mask};
            ADDR_STATE: dat_o <= {{29{1'b0}}, blocked_o, pressed, sense};
            default: dat_o <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= CTRL_RESET;
         obj_cfg <= OBJCFG_RESET;
         mask <= '0;
         blk_val <= 1'b0;
      end else if (wb_wr) begin
         if (adr_i == ADDR_CTRL) begin
            ctrl <= merge(ctrl, dat_i, sel_i) & CTRL_WMASK;
         end
         if (adr_i == ADDR_OBJCFG) begin
            obj_cfg <= merge(obj_cfg, dat_i, sel_i) & OBJCFG_WMASK;
         end
         if (adr_i == ADDR_MASK && sel_i[0]) begin
            mask <= dat_i[ST_BITS-1:0];
         end
         if (adr_i == ADDR_BLOCK && sel_i[0]) begin
            blk_val <= dat_i[0];
         end
      end
   end

   // Time base: millisecond, second and minute ticks, free running
   always_ff @(posedge clk_i) begin
      if (rst_i || ms_tick) begin
         tick_cnt <= '0;
      end else begin
         tick_cnt <= tick_cnt + 17'h0_0001;
      end
   end
   assign ms_tick = tick_cnt == 17'(TICK_CYCLES - 1); // see (RULE14)

   always_ff @(posedge clk_i) begin
      if (rst_i || sec_tick) begin
         ms_cnt <= '0;
      end else if (ms_tick) begin
         ms_cnt <= ms_cnt + 10'h001;
      end
   end
   assign sec_tick = ms_tick && ms_cnt == 10'(MS_PER_S - 1);

   always_ff @(posedge clk_i) begin
      if (rst_i || min_tick) begin
         sec_cnt <= '0;
      end else if (sec_tick) begin
         sec_cnt <= sec_cnt + 6'h01;
      end
   end
   assign min_tick = sec_tick && sec_cnt == 6'(S_PER_MIN - 1);

   // Period of zero is taken as one minute, above sixty as sixty
   always_comb begin
      cyc_min = ctrl.cyc_min;
      if (ctrl.cyc_min == 6'h00) begin
         cyc_min = 6'h01;
      end else if (ctrl.cyc_min > 6'(CYC_MAX_MIN)) begin
         cyc_min = 6'(CYC_MAX_MIN);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || cyc_tick) begin
         min_cnt <= '0;
      end else if (min_tick) begin
         min_cnt <= min_cnt + 6'h01;
      end
   end
   assign cyc_tick = min_tick && min_cnt >= cyc_min - 6'h01; // see (RULE2)

   // Debounce of the contact, counted in ms ticks while the level differs
   assign sense = contact_i ^ ctrl.opening; // see (RULE8)
   assign deb_ms = 14'(DEB_MS_TAB[ctrl.deb_sel]);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pressed <= 1'b0;
         deb_cnt <= '0;
      end else if (sense == pressed) begin
         deb_cnt <= '0;
      end else if (ms_tick) begin
         if (deb_cnt + 14'h0001 >= deb_ms) begin
            pressed <= sense; // see (RULE7)
            deb_cnt <= '0;
         end else begin
            deb_cnt <= deb_cnt + 14'h0001;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pressed_d <= 1'b0;
      end else begin
         pressed_d <= pressed;
      end
   end
   assign rise = ctrl.chan_en & pressed & ~pressed_d;
   assign fall = ctrl.chan_en & ~pressed & pressed_d;

   // Press classification
   assign long_ms = 11'(PRESS_BASE_MS + PRESS_STEP_MS * ctrl.long_sel);
   assign dbl_ms = 11'(PRESS_BASE_MS + PRESS_STEP_MS * ctrl.dbl_sel);

   always_comb begin
      next_pst = pst;
      restart_t = 1'b0;
      evt = '0;
      evt.rise = rise;
      evt.fall = fall;
      unique case (pst)
         PS_IDLE: begin
            if (rise) begin
               next_pst = PS_PRESS;
               restart_t = 1'b1; // see (RULE14)
            end
         end
         PS_PRESS: begin
            if (fall) begin
               next_pst = PS_WAIT;
            end else if (press_ms >= long_ms) begin
               evt.lng = 1'b1; // see (RULE9)
               next_pst = PS_HELD;
            end
         end
         PS_WAIT: begin
            if (press_ms >= dbl_ms) begin
               evt.shrt = 1'b1; // see (RULE9)
               next_pst = rise ? PS_PRESS : PS_IDLE;
               restart_t = rise;
            end else if (rise) begin
               evt.dbl = 1'b1; // see (RULE10)
               next_pst = PS_HELD;
            end
         end
         PS_HELD: begin
            if (fall) begin
               next_pst = PS_IDLE;
            end
         end
         default: next_pst = PS_IDLE;
      endcase
      if (!ctrl.chan_en) begin
         next_pst = PS_IDLE;
         evt = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pst <= PS_IDLE;
      end else begin
         pst <= next_pst;
      end
   end

   // Saturates well above the longest window
   always_ff @(posedge clk_i) begin
      if (rst_i || restart_t) begin
         press_ms <= '0;
      end else if (ms_tick && press_ms != 11'h7FF) begin
         press_ms <= press_ms + 11'h001;
      end
   end

   // Block function
   assign block_act = ctrl.blk_en & (blk_val ^ ctrl.blk_inv); // see (RULE12) (RULE13)

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         block_d <= 1'b0;
         supply_d <= 1'b0;
      end else begin
         block_d <= block_act;
         supply_d <= bus_supply_i;
      end
   end
   assign blk_set = ctrl.chan_en & block_act & ~block_d;
   assign blk_clr = ctrl.chan_en & ~block_act & block_d;
   assign bus_ret = ctrl.chan_en & bus_supply_i & ~supply_d;
   assign blocked_o = block_d;
   assign pressed_o = pressed_d;

   // Objects in use; a count of zero is taken as one
   assign obj_count = ctrl.obj_count == 2'h0 ? 2'h1 : ctrl.obj_count;

   for (genvar i = 0; i < OBJ_NUM; i++) begin : g_obj
      obj_sched u_obj (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .in_use_i(ctrl.chan_en && 2'(i) < obj_count), // see (RULE11)
         .level_i(pressed),
         .blocked_i(block_act), // see (RULE6)
         .cyc_tick_i(cyc_tick),
         .sec_tick_i(sec_tick),
         .bus_ret_i(bus_ret),
         .blk_set_i(blk_set),
         .blk_clr_i(blk_clr),
         .cfg_i(obj_cfg[8*i +: 8]),
         .evt_i(evt),
         .tx_req_o(tx_req_o[i]),
         .tx_cause_o(tx_cause_o[i])
      );
   end

   // Sticky status; a read clears it, but an event in the same cycle survives
   always_comb begin
      st_set = '0;
      st_set[ST_RISE] = evt.rise;
      st_set[ST_FALL] = evt.fall;
      st_set[ST_SHORT] = evt.shrt;
      st_set[ST_LONG] = evt.lng;
      st_set[ST_DOUBLE] = evt.dbl;
      st_set[ST_TX] = |tx_req_o;
      st_set[ST_BLOCK] = blk_set | blk_clr;
      st_set[ST_BUSRET] = bus_ret;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status <= '0;
      end else if (wb_rd && adr_i == ADDR_STATUS) begin
         status <= st_set;
      end else begin
         status <= status | st_set;
      end
   end

   assign irq_o = |(status & mask);
endmodule : pb_channel

// file: shared/pb_pkg.sv
// Constants, register map and shared types of the push button input channel
package pb_pkg;
   // Time base
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned MS_PER_S = 1000;
   localparam int unsigned CYCLES_PER_MS = CLK_HZ / MS_PER_S;
   localparam int unsigned S_PER_MIN = 60;
   localparam int unsigned DEB_MS_TAB [8] = '{30, 50, 80, 100, 200, 1000, 5000, 10000};
   localparam int unsigned PRESS_BASE_MS = 300;
   localparam int unsigned PRESS_STEP_MS = 100;
   localparam int unsigned RET_DELAY_S [8] = '{0, 0, 5, 10, 15, 0, 0, 0};
   localparam int unsigned CYC_MAX_MIN = 60;
   localparam int unsigned OBJ_NUM = 3;
   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_OBJCFG = 8'h04;
   localparam logic [7:0] ADDR_BLOCK = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_MASK = 8'h10;
   localparam logic [7:0] ADDR_STATE = 8'h14;
   // Reset values and writable bits
   localparam logic [31:0] CTRL_RESET = 32'h0101_0011;
   localparam logic [31:0] CTRL_WMASK = 32'h033F_777F;
   localparam logic [31:0] OBJCFG_RESET = 32'h0000_0000;
   localparam logic [31:0] OBJCFG_WMASK = 32'h00FF_FFFF;
   // Status bit positions
   localparam int unsigned ST_RISE = 0;
   localparam int unsigned ST_FALL = 1;
   localparam int unsigned ST_SHORT = 2;
   localparam int unsigned ST_LONG = 3;
   localparam int unsigned ST_DOUBLE = 4;
   localparam int unsigned ST_TX = 5;
   localparam int unsigned ST_BLOCK = 6;
   localparam int unsigned ST_BUSRET = 7;
   localparam int unsigned ST_BITS = 8;
   // Per-object mode encodings
   localparam logic [1:0] CYC_NEVER = 2'h0;
   localparam logic [1:0] CYC_ALWAYS = 2'h1;
   localparam logic [1:0] CYC_HIGH = 2'h2;
   localparam logic [1:0] CYC_LOW = 2'h3;
   localparam logic [2:0] RET_NONE = 3'h0;
   localparam logic [2:0] RET_NOW = 3'h1;
   localparam logic [2:0] RET_5S = 3'h2;
   localparam logic [2:0] RET_15S = 3'h4;
   localparam logic [1:0] RESP_IGNORE = 2'h0;
   localparam logic [1:0] RESP_NONE = 2'h1;
   localparam logic [1:0] RESP_RISE = 2'h2;
   localparam logic [1:0] RESP_FALL = 2'h3;

   typedef struct packed {
      logic [5:0] rsv_hi;
      logic [1:0] obj_count;
      logic [1:0] rsv_c;
      logic [5:0] cyc_min;
      logic rsv_b;
      logic [2:0] dbl_sel;
      logic rsv_a;
      logic [2:0] long_sel;
      logic rsv_0;
      logic [2:0] deb_sel;
      logic blk_inv;
      logic blk_en;
      logic opening;
      logic chan_en;
   } ctrl_t;

   typedef struct packed {
      logic rel_update;
      logic [1:0] set_resp;
      logic [2:0] ret_mode;
      logic [1:0] cyc_mode;
   } obj_cfg_t;

   typedef struct packed {
      logic dbl;
      logic lng;
      logic shrt;
      logic fall;
      logic rise;
   } chan_evt_t;

   typedef enum logic [2:0] {
      C_RISE = 3'h0,
      C_FALL = 3'h1,
      C_SHORT = 3'h2,
      C_LONG = 3'h3,
      C_DOUBLE = 3'h4,
      C_CYCLIC = 3'h5,
      C_UPDATE = 3'h6
   } cause_t;

   typedef enum logic [3:0] {
      PS_IDLE = 4'h1,
      PS_PRESS = 4'h2,
      PS_WAIT = 4'h4,
      PS_HELD = 4'h8
   } press_st_t;
endpackage : pb_pkg

// file: rtl/obj_sched.sv
// Telegram scheduler of one output object of the input channel
`timescale 1ns/1ps
module obj_sched
   import pb_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic in_use_i,
   input wire logic level_i,
   input wire logic blocked_i,
   input wire logic cyc_tick_i,
   input wire logic sec_tick_i,
   input wire logic bus_ret_i,
   input wire logic blk_set_i,
   input wire logic blk_clr_i,
   input wire obj_cfg_t cfg_i,
   input wire chan_evt_t evt_i,
   output logic tx_req_o,
   output cause_t tx_cause_o
);
   logic [3:0] ret_cnt;
   logic ret_pend;
   logic ignore_blk;
   logic held;
   logic ret_fire;
   logic cyc_ok;
   logic next_req;
   cause_t next_cause;

   assign ignore_blk = cfg_i.set_resp == RESP_IGNORE;
   assign held = blocked_i & ~ignore_blk;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ret_pend <= 1'b0;
         ret_cnt <= 4'h0;
      end else if (bus_ret_i) begin
         ret_pend <= cfg_i.ret_mode >= RET_5S && cfg_i.ret_mode <= RET_15S; // see (RULE3)
         ret_cnt <= 4'(RET_DELAY_S[cfg_i.ret_mode]);
      end else if (ret_pend && sec_tick_i) begin
         ret_pend <= ret_cnt != 4'h1;
         ret_cnt <= ret_cnt - 4'h1;
      end
   end

   assign ret_fire = (bus_ret_i && cfg_i.ret_mode == RET_NOW) ||
                     (ret_pend && sec_tick_i && ret_cnt == 4'h1); // see (RULE3)

   always_comb begin
      unique case (cfg_i.cyc_mode) // see (RULE1)
         CYC_NEVER: cyc_ok = 1'b0;
         CYC_ALWAYS: cyc_ok = 1'b1;
         CYC_HIGH: cyc_ok = level_i;
         CYC_LOW: cyc_ok = ~level_i;
      endcase
   end

   // One telegram per cycle; simultaneous causes resolve by this order
   always_comb begin
      next_req = 1'b1;
      next_cause = C_UPDATE;
      if (blk_set_i && cfg_i.set_resp == RESP_RISE) begin
         next_cause = C_RISE; // see (RULE4)
      end else if (blk_set_i && cfg_i.set_resp == RESP_FALL) begin
         next_cause = C_FALL; // see (RULE4)
      end else if (blk_clr_i && !ignore_blk && cfg_i.rel_update) begin
         next_cause = C_UPDATE; // see (RULE5)
      end else if (ret_fire) begin
         next_cause = C_UPDATE;
      end else if (!held && evt_i.rise) begin
         next_cause = C_RISE; // see (RULE4)
      end else if (!held && evt_i.fall) begin
         next_cause = C_FALL;
      end else if (!held && evt_i.shrt) begin
         next_cause = C_SHORT;
      end else if (!held && evt_i.lng) begin
         next_cause = C_LONG;
      end else if (!held && evt_i.dbl) begin
         next_cause = C_DOUBLE;
      end else if (cyc_tick_i && cyc_ok && !blocked_i) begin
         next_cause = C_CYCLIC; // see (RULE6)
      end else begin
         next_req = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_req_o <= 1'b0;
         tx_cause_o <= C_RISE;
      end else begin
         tx_req_o <= in_use_i & next_req; // see (RULE11)
         if (next_req) begin
            tx_cause_o <= next_cause;
         end
      end
   end
endmodule : obj_sched

// file: tb/pb_channel_properties.sv
// Port-level concurrent checks of the push button input channel
`timescale 1ns/1ps
module pb_channel_properties
   import pb_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = CYCLES_PER_MS
)(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic contact_i,
   input wire logic bus_supply_i,
   input wire logic [2:0] tx_req_o,
   input wire cause_t [2:0] tx_cause_o,
   input wire logic pressed_o,
   input wire logic blocked_o,
   input wire logic irq_o
);
   // Two ticks of slack: a settle count may start just before a tick
   localparam int unsigned MIN_HOLD = 28 * TICK_CYCLES;
   localparam int unsigned MIN_LONG = 298 * TICK_CYCLES;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic prev;
   logic [19:0] held;
   logic wr;
   logic cyc_tx;
   assign wr = cyc_i && stb_i && we_i;
   assign cyc_tx = (tx_req_o[0] && tx_cause_o[0] == C_CYCLIC) ||
      (tx_req_o[1] && tx_cause_o[1] == C_CYCLIC) || (tx_req_o[2] && tx_cause_o[2] == C_CYCLIC);
   always_ff @(posedge clk_i) begin
      prev <= pressed_o;
      if (rst_i || pressed_o != prev) held <= 20'h0_0000;
      else if (held != 20'hF_FFFF) held <= held + 20'h0_0001;
   end
   ack_time_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("bus request not answered in the next cycle");
   ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i && !ack_o))
      else $error("acknowledge without a request");
   ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("acknowledge longer than one cycle");
   unmapped_zero_a: assert property (ack_o && !$past(we_i) && $past(adr_i) > ADDR_STATE
      |-> dat_o == 32'h0000_0000) else $error("unmapped read not zero");
   status_rsv_a: assert property (ack_o && !$past(we_i) && $past(adr_i) == ADDR_STATUS
      |-> dat_o[31:8] == 24'h00_0000) else $error("status reserved bits set");
   cause_hold_a: assert property (tx_req_o == 3'h0 |-> $stable(tx_cause_o))
      else $error("telegram cause moved without a request");
   cyc_block_a: assert property (blocked_o && $past(blocked_o) |-> !cyc_tx)
      else $error("cyclic telegram while blocked");
   debounce_a: assert property (pressed_o != prev |-> held >= MIN_HOLD)
      else $error("pressed level moved before settle time");
   long_time_a: assert property (tx_req_o[0] && tx_cause_o[0] == C_LONG
      |-> pressed_o && held >= MIN_LONG) else $error("long press reported early");
   block_src_a: assert property (blocked_o != $past(blocked_o)
      |-> $past(wr) || $past(wr, 2) || $past(wr, 3)) else $error("block moved without write");
   long_c: cover property (tx_req_o[0] && tx_cause_o[0] == C_LONG);
   cyclic_c: cover property (cyc_tx);
   update_c: cover property (tx_req_o[1] && tx_cause_o[1] == C_UPDATE);
endmodule : pb_channel_properties

// file: tb/pb_far_side.sv
// Far side model: a chattering contact and a telegram counter per object
`timescale 1ns/1ps
module pb_far_side (
   input wire logic clk_i,
   input wire logic closed_i,
   input wire logic bounce_i,
   input wire logic [2:0] tx_req_i,
   output logic contact_o = 1'b0,
   output logic [2:0][7:0] tx_cnt_o = '0
);
   logic [2:0] ph = 3'h0;
   // Chatter flips every 4 cycles, far below the shortest settle time
   always @(posedge clk_i) begin
      ph <= ph + 3'h1;
      contact_o <= bounce_i ? ph[2] : closed_i;
      for (int i = 0; i < 3; i++) tx_cnt_o[i] <= tx_cnt_o[i] + 8'(tx_req_i[i]);
   end
endmodule : pb_far_side

// file: tb/tb_push_button_input_channel.sv
// Self-checking bench of the push button input channel
`timescale 1ns/1ps
module tb_push_button_input_channel;
   import pb_pkg::*;
   localparam int unsigned TICK = 1;
   typedef struct {logic [7:0] a; logic w; logic [31:0] d;} row_t;
   logic clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0000_0000;
   logic [3:0] sel_i = 4'hF;
   logic bus_supply_i = 1'b0, closed = 1'b0, bounce = 1'b0, contact_i;
   logic [31:0] dat_o, rd;
   logic ack_o, pressed_o, blocked_o, irq_o;
   logic [2:0] tx_req_o;
   cause_t [2:0] tx_cause_o;
   logic [2:0][7:0] tx_cnt, snap;
   int errors = 0, comparisons = 0, cyc_n = 0;
   row_t rows [14] = '{
      '{ADDR_CTRL, 1'b0, CTRL_RESET}, '{ADDR_OBJCFG, 1'b0, OBJCFG_RESET},
      '{ADDR_BLOCK, 1'b0, 32'h0000_0000}, '{ADDR_STATUS, 1'b0, 32'h0000_0000},
      '{ADDR_MASK, 1'b0, 32'h0000_0000}, '{ADDR_STATE, 1'b0, 32'h0000_0000},
      '{8'h18, 1'b1, 32'hFFFF_FFFF}, '{8'h18, 1'b0, 32'h0000_0000},
      '{ADDR_MASK, 1'b1, 32'hFFFF_FFFF}, '{ADDR_MASK, 1'b0, 32'h0000_00FF},
      '{ADDR_OBJCFG, 1'b1, 32'h0073_2AC5}, '{ADDR_OBJCFG, 1'b0, 32'h0073_2AC5},
      '{ADDR_CTRL, 1'b1, 32'h0301_0001}, '{ADDR_CTRL, 1'b0, 32'h0301_0001}};
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) cyc_n <= rst_i ? 0 : cyc_n + 1;
   pb_channel #(.TICK_CYCLES(TICK)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
      .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
      .ack_o(ack_o), .contact_i(contact_i), .bus_supply_i(bus_supply_i), .tx_req_o(tx_req_o),
      .tx_cause_o(tx_cause_o), .pressed_o(pressed_o), .blocked_o(blocked_o), .irq_o(irq_o));
   pb_far_side u_far (.clk_i(clk_i), .closed_i(closed), .bounce_i(bounce),
      .tx_req_i(tx_req_o), .contact_o(contact_i), .tx_cnt_o(tx_cnt));
   task automatic results();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
   endtask : idle
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      adr_i <= a;
      we_i <= w;
      dat_i <= d;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      rd = dat_o;
      chk(32'(ack_o), 32'h0000_0001);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic wait_tx(input int o, input cause_t c, input int lo, input int hi);
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (tx_req_o[o] !== 1'b1 && n < hi);
      chk(32'(n >= lo && tx_req_o[o] === 1'b1), 32'h0000_0001);
      chk(32'(tx_cause_o[o]), 32'(c));
   endtask : wait_tx
   task automatic cnt_chk(input logic [23:0] delta);
      chk(32'(tx_cnt), 32'(snap + delta));
      snap = tx_cnt;
   endtask : cnt_chk
   initial begin
      repeat (90000) @(posedge clk_i);
      errors++;
      results();
   end
   initial begin
      idle(2);
      rst_i <= 1'b0;
      @(posedge clk_i);
      foreach (rows[i]) begin
         wb(rows[i].a, rows[i].w, rows[i].d);
         if (!rows[i].w) chk(rd, rows[i].d);
      end
      $display("register table done");
      bounce <= 1'b1;
      idle(100);
      chk(32'(pressed_o), 32'h0000_0000);
      bounce <= 1'b0;
      closed <= 1'b1;
      wait_tx(0, C_RISE, 30, 40);
      chk(32'(tx_req_o), 32'h0000_0007);
      wait_tx(0, C_LONG, 295, 306);
      closed <= 1'b0;
      wait_tx(0, C_FALL, 30, 40);
      idle(400);
      chk(32'(irq_o), 32'h0000_0001);
      wb(ADDR_STATUS, 1'b0, 32'h0000_0000);
      chk(rd, 32'h0000_002B);
      wb(ADDR_STATUS, 1'b0, 32'h0000_0000);
      chk(rd | 32'(irq_o), 32'h0000_0000);
      $display("debounce and long press done");
      closed <= 1'b1;
      wait_tx(0, C_RISE, 30, 40);
      idle(70);
      closed <= 1'b0;
      wait_tx(0, C_FALL, 30, 40);
      wait_tx(0, C_SHORT, 185, 212);
      wb(ADDR_STATUS, 1'b0, 32'h0000_0000);
      closed <= 1'b1;
      wait_tx(0, C_RISE, 30, 40);
      idle(40);
      closed <= 1'b0;
      wait_tx(0, C_FALL, 30, 40);
      closed <= 1'b1;
      idle(60);
      closed <= 1'b0;
      idle(400);
      wb(ADDR_STATUS, 1'b0, 32'h0000_0000);
      chk(rd, 32'h0000_0033);
      $display("short and double click done");
      wb(ADDR_CTRL, 1'b1, 32'h0301_0003);
      wait_tx(0, C_RISE, 28, 40);
      closed <= 1'b1;
      wait_tx(0, C_FALL, 30, 40);
      closed <= 1'b0;
      wb(ADDR_CTRL, 1'b1, 32'h0101_0001);
      closed <= 1'b1;
      wait_tx(0, C_RISE, 30, 40);
      chk(32'(tx_req_o), 32'h0000_0001);
      closed <= 1'b0;
      idle(400);
      $display("contact type and object count done");
      snap = tx_cnt;
      wb(ADDR_CTRL, 1'b1, 32'h0301_0005);
      wb(ADDR_BLOCK, 1'b1, 32'h0000_0001);
      idle(5);
      chk(32'(blocked_o), 32'h0000_0001);
      chk(32'({tx_cause_o[2], tx_cause_o[0]}), 32'({C_FALL, C_RISE}));
      cnt_chk(24'h01_0001);
      closed <= 1'b1;
      idle(60);
      closed <= 1'b0;
      idle(400);
      cnt_chk(24'h00_0000);
      wb(ADDR_BLOCK, 1'b1, 32'h0000_0000);
      idle(5);
      chk(32'(tx_cause_o[0]), 32'(C_UPDATE));
      cnt_chk(24'h00_0001);
      wb(ADDR_CTRL, 1'b1, 32'h0301_000D);
      idle(5);
      chk(32'(blocked_o), 32'h0000_0001);
      wb(ADDR_BLOCK, 1'b1, 32'h0000_0001);
      idle(5);
      chk(32'(blocked_o), 32'h0000_0000);
      wb(ADDR_CTRL, 1'b1, 32'h0301_0001);
      idle(5);
      chk(32'(blocked_o), 32'h0000_0000);
      $display("block function done");
      snap = tx_cnt;
      bus_supply_i <= 1'b1;
      wait_tx(0, C_UPDATE, 1, 4);
      wait_tx(1, C_UPDATE, 4000, 5010);
      wait_tx(2, C_UPDATE, 9995, 10005);
      bus_supply_i <= 1'b0;
      // Object 1 never cyclic, object 2 ignores the block
      wb(ADDR_OBJCFG, 1'b1, 32'h0003_2CC5);
      bus_supply_i <= 1'b1;
      wait_tx(0, C_UPDATE, 1, 4);
      wait_tx(1, C_UPDATE, 9000, 10010);
      idle(6000);
      cnt_chk(24'h01_0202);
      $display("bus return done");
      wb(ADDR_CTRL, 1'b1, 32'h0301_0005);
      closed <= 1'b1;
      wait_tx(2, C_RISE, 30, 40);
      chk(32'(tx_req_o), 32'h0000_0004);
      closed <= 1'b0;
      idle(400);
      wb(ADDR_BLOCK, 1'b1, 32'h0000_0000);
      $display("ignored block done");
      wait_tx(0, C_CYCLIC, 1, 40000);
      chk(32'(cyc_n >= 59990), 32'h0000_0001);
      chk(32'(tx_req_o), 32'h0000_0005);
      chk(32'(tx_cause_o[2]), 32'(C_CYCLIC));
      $display("cyclic done");
      results();
   end
endmodule : tb_push_button_input_channel
bind pb_channel pb_channel_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (.clk_i(clk_i),
   .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .contact_i(contact_i),
   .bus_supply_i(bus_supply_i), .tx_req_o(tx_req_o), .tx_cause_o(tx_cause_o),
   .pressed_o(pressed_o), .blocked_o(blocked_o), .irq_o(irq_o));
